// ---- pcgpio_port.sv ----
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pcgpio_defs.svh"
//
// Contract
// - Eight pins, each with direction, latch and pin-data bits.
// - Direction 1 is input; 0 drives the pin from the latch.
// - Writing pin data register loads the output latches.
// - Every pin is a digital input after reset.
// - Enabled peripherals override pin direction; here I2C, the secondary oscillator and the PWM shutdown tri-state do.
// - Direction read returns stored bits despite overrides.
// - Don't-care functions act regardless of direction bit.
// - Open-drain select for compare, SPI and USART pin functions.
// - Compare two on pin 1 when map bit is 1; output beats latch.
// - Pin 2 carries compare one output, else feeds its capture.
// - PWM channel A may tri-state during shutdown.
// - Pin 3 drives SPI clock when output, else clock input.
// - I2C clock and data on pins 3 and 4 override the latch.
// - SPI data in on pin 4, data out on pin 5 when output.
// - USART transmit on pin 6 overrides latch; pin 7 receives.
// - Sync USART: pin 6 clock, pin 7 data; software sets input.
// - Pin 0 external clock only while secondary oscillator off.
module pcgpio_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  input wire logic ccp1_en,
  input wire logic ccp1_out,
  input wire logic p1a_shutdown,
  output logic ccp1_capture_in,
  input wire logic ccp2_en,
  input wire logic ccp2_out,
  input wire logic p2a_shutdown,
  output logic ccp2_capture_in,
  input wire logic [1:0] ser_mode,
  input wire logic spi_clock_out,
  input wire logic spi_data_out,
  output logic spi_clock_in,
  output logic spi_data_in,
  input wire logic i2c_clock_oe,
  input wire logic i2c_data_oe,
  output logic i2c_clock_in,
  output logic i2c_data_in,
  input wire logic usart_en,
  input wire logic usart_sync,
  input wire logic usart_transmit,
  input wire logic usart_sync_data_out,
  output logic usart_receive_in,
  output logic usart_sync_clock_in,
  output logic ext_digital_clock_in
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  pcgpio_pkg::pcgpio_byte_t dir_q;
  pcgpio_pkg::pcgpio_byte_t latch_q;
  pcgpio_pkg::pcgpio_byte_t od_a_q;
  pcgpio_pkg::pcgpio_byte_t od_b_q;
  pcgpio_pkg::pcgpio_byte_t periph_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [7:0] sync3_q;
  logic [7:0] pins_q;
  logic [7:0] drv_d;
  logic [7:0] oe_d;
  logic [7:0] cap_d;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic spi_on;
  logic i2c_on;
  logic ccp2_here;
  logic secondary_oscillator_on;
  logic [31:0] rdata_d;

  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_en = psel && !penable && !pwrite;
  assign spi_on = ser_mode == 2'(pcgpio_pkg::PCGPIO_SER_SPI);
  assign i2c_on = ser_mode == 2'(pcgpio_pkg::PCGPIO_SER_I2C);
  assign ccp2_here = periph_q[`PCG_PC_CCP2_MAP];
  assign secondary_oscillator_on = periph_q[`PCG_PC_SECONDARY_OSCILLATOR_EN];

  // ----------------------------------------
  // Pin input synchroniser
  // ----------------------------------------
  // Three stages; a change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      sync3_q <= 8'h00;
      pins_q <= 8'h00;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pins_q <= (sync2_q & sync3_q) | (pins_q & (sync2_q ^ sync3_q));
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Writes take effect in the access phase only; always zero-wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_q <= `PCG_RST_DIR;
      latch_q <= `PCG_RST_LATCH;
      od_a_q <= `PCG_RST_OD;
      od_b_q <= `PCG_RST_OD;
      periph_q <= `PCG_RST_PERIPH;
    end
    else if (wr_en)
    begin
      case (paddr)
        `PCG_OFF_PIN_DATA: latch_q <= pwdata[7:0];
        `PCG_OFF_LATCH: latch_q <= pwdata[7:0];
        `PCG_OFF_DIR: dir_q <= pwdata[7:0];
        `PCG_OFF_OD_A: od_a_q <= pwdata[7:0] & 8'he1;
        `PCG_OFF_OD_B: od_b_q <= pwdata[7:0] & 8'hc1;
        `PCG_OFF_PERIPH: periph_q <= pwdata[7:0] & 8'h0f;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Pin muxing
  // ----------------------------------------
  always_comb
  begin
    drv_d = latch_q;
    oe_d = ~dir_q;
    cap_d = 8'h00;
    // oscillator owns pins 0 and 1
    if (secondary_oscillator_on)
    begin
      oe_d[1:0] = 2'b00;
    end
    if (ccp2_en && ccp2_here && !secondary_oscillator_on)
    begin
      drv_d[1] = ccp2_out;
      if (periph_q[`PCG_PC_P2A_TRI] && p2a_shutdown)
        oe_d[1] = 1'b0;
      if (od_a_q[`PCG_ODA_COMPARE_TWO] && ccp2_out)
        oe_d[1] = 1'b0;
    end
    if (ccp1_en)
    begin
      drv_d[2] = ccp1_out;
      if (periph_q[`PCG_PC_P1A_TRI] && p1a_shutdown)
        oe_d[2] = 1'b0;
      if (od_a_q[`PCG_ODA_COMPARE_ONE] && ccp1_out)
        oe_d[2] = 1'b0;
    end
    if (spi_on)
    begin
      drv_d[3] = spi_clock_out;
      // SPI data out on pin 5
      drv_d[5] = spi_data_out;
      if (od_a_q[`PCG_ODA_SERIAL_ONE])
      begin
        oe_d[3] = oe_d[3] && !spi_clock_out;
        oe_d[5] = oe_d[5] && !spi_data_out;
      end
    end
    // I2C pulls pins low, overriding direction
    if (i2c_on)
    begin
      drv_d[4:3] = 2'b00;
      oe_d[3] = i2c_clock_oe;
      oe_d[4] = i2c_data_oe;
    end
    if (usart_en)
    begin
      // sync mode: pin 6 clock, pin 7 data, direction from software
      drv_d[6] = usart_transmit;
      if (usart_sync)
        drv_d[7] = usart_sync_data_out;
      if (od_b_q[`PCG_ODB_USART_ONE])
      begin
        oe_d[6] = oe_d[6] && !drv_d[6];
        oe_d[7] = oe_d[7] && !drv_d[7];
      end
    end
    cap_d = pins_q;
  end

  // ----------------------------------------
  // Registered pin and peripheral outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      ccp1_capture_in <= 1'b0;
      ccp2_capture_in <= 1'b0;
      spi_clock_in <= 1'b0;
      spi_data_in <= 1'b0;
      i2c_clock_in <= 1'b1;
      i2c_data_in <= 1'b1;
      usart_receive_in <= 1'b1;
      usart_sync_clock_in <= 1'b0;
      ext_digital_clock_in <= 1'b0;
    end
    else
    begin
      pin_out <= drv_d;
      pin_oe <= oe_d;
      // capture inputs follow the pins regardless of direction
      ccp1_capture_in <= cap_d[2];
      ccp2_capture_in <= ccp2_here ? cap_d[1] : 1'b0;
      spi_clock_in <= cap_d[3];
      // SPI data in on pin 4
      spi_data_in <= cap_d[4];
      i2c_clock_in <= cap_d[3];
      i2c_data_in <= cap_d[4];
      usart_receive_in <= cap_d[7];
      usart_sync_clock_in <= cap_d[6];
      // clock input only with oscillator off
      ext_digital_clock_in <= secondary_oscillator_on ? 1'b0 : cap_d[0];
    end
  end

  // ----------------------------------------
  // APB read path
  // ----------------------------------------
  always_comb
  begin
    hit = 1'b1;
    rdata_d = 32'h0000_0000;
    case (paddr)
      `PCG_OFF_PIN_DATA: rdata_d[7:0] = pins_q;
      `PCG_OFF_LATCH: rdata_d[7:0] = latch_q;
      `PCG_OFF_DIR: rdata_d[7:0] = dir_q;
      `PCG_OFF_OD_A: rdata_d[7:0] = od_a_q;
      `PCG_OFF_OD_B: rdata_d[7:0] = od_b_q;
      `PCG_OFF_PERIPH: rdata_d[7:0] = periph_q;
      default: hit = 1'b0;
    endcase
  end

  // Data captured in setup so it comes from a flop in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd_en)
        prdata <= rdata_d;
    end
  end
endmodule // pcgpio_port
`default_nettype wire

// ---- pcgpio_defs.svh ----
`ifndef PCGPIO_DEFS_SVH
`define PCGPIO_DEFS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PCG_OFF_PIN_DATA 12'h000
`define PCG_OFF_LATCH 12'h004
`define PCG_OFF_DIR 12'h008
`define PCG_OFF_OD_A 12'h00c
`define PCG_OFF_OD_B 12'h010
`define PCG_OFF_PERIPH 12'h014
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PCG_RST_DIR 8'hff
`define PCG_RST_LATCH 8'h00
`define PCG_RST_OD 8'h00
`define PCG_RST_PERIPH 8'h01
// ----------------------------------------
// Open-drain control field positions
// ----------------------------------------
`define PCG_ODA_SERIAL_ONE 7
`define PCG_ODA_COMPARE_TWO 6
`define PCG_ODA_COMPARE_ONE 5
`define PCG_ODA_SERIAL_TWO 0
`define PCG_ODB_USART_TWO 7
`define PCG_ODB_USART_ONE 6
`define PCG_ODB_CHARGE_TIMER 0
// ----------------------------------------
// Peripheral control field positions
// ----------------------------------------
`define PCG_PC_CCP2_MAP 0
`define PCG_PC_SECONDARY_OSCILLATOR_EN 1
`define PCG_PC_P1A_TRI 2
`define PCG_PC_P2A_TRI 3
`endif

// ---- pcgpio_pkg.sv ----
package pcgpio_pkg;
  typedef logic [7:0] pcgpio_byte_t;
  typedef enum logic [1:0] {PCGPIO_SER_OFF, PCGPIO_SER_SPI, PCGPIO_SER_I2C} pcgpio_ser_e;
endpackage

// ---- pcgpio_port_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcgpio_defs.svh"
module pcgpio_port_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic ccp1_en,
  input wire logic ccp1_out,
  input wire logic p1a_shutdown,
  input wire logic [1:0] ser_mode,
  input wire logic spi_clock_out,
  input wire logic i2c_clock_oe,
  input wire logic i2c_data_oe
);
  logic [7:0] dir_q;
  // Shadow of the stored direction, so overrides can be told apart
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      dir_q <= `PCG_RST_DIR;
    else if (psel && penable && pwrite && pstrb[0] && paddr == `PCG_OFF_DIR)
      dir_q <= pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  property p_ready; s_setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_reset; $rose(presetn) |-> pin_oe == 8'h00; endproperty
  a_reset: assert property (p_reset) else $error("pin driven after reset");
  property p_dir; $past(ser_mode) == 2'h0 |-> pin_oe[5] == !$past(dir_q[5]); endproperty
  a_dir: assert property (p_dir) else $error("direction not followed");
  property p_ccp1;
    $past(ccp1_en) && !$past(p1a_shutdown) && pin_oe[2] |-> pin_out[2] == $past(ccp1_out);
  endproperty
  a_ccp1: assert property (p_ccp1) else $error("compare one not on pin");
  property p_spi; $past(ser_mode) == 2'h1 && pin_oe[3] |-> pin_out[3] == $past(spi_clock_out);
  endproperty
  a_spi: assert property (p_spi) else $error("spi clock not on pin");
  // I2C enables ignore direction; first edge after reset still shows reset drive
  property p_i2c; $past(presetn) && $past(ser_mode) == 2'h2 |->
    pin_oe[4] == $past(i2c_data_oe) && pin_oe[3] == $past(i2c_clock_oe); endproperty
  a_i2c: assert property (p_i2c) else $error("i2c enables not on pins");
endmodule // pcgpio_port_asserts
bind pcgpio_port pcgpio_port_asserts u_chk (.*);
`default_nettype wire

// ---- pcgpio_pads.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcgpio_pads (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext,
  output logic [7:0] pin_in
);
  // far side drives released pins only
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule // pcgpio_pads
`default_nettype wire

// ---- pcgpio_port_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcgpio_port_bench;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, cap1, rx, xclk;
  logic [7:0] pin_in, pin_out, pin_oe;
  logic [7:0] ext = 8'h0;
  logic [15:0] pv = 16'h0;
  int n_errors = 0;
  int n_checks = 0;
  logic [15:0] tv [5] = '{16'h0003, 16'h0018, 16'h40c0, 16'h1400, 16'h2c00};
  logic [7:0] te [5] = '{8'h04, 8'h02, 8'h28, 8'h40, 8'h80};
  always #10 pclk = ~pclk;
  pcgpio_port u_dut (.*, .ccp1_en(pv[0]), .ccp1_out(pv[1]), .p1a_shutdown(pv[2]),
    .ccp2_en(pv[3]), .ccp2_out(pv[4]), .p2a_shutdown(pv[5]), .ccp1_capture_in(cap1),
    .ccp2_capture_in(), .ser_mode(pv[15:14]), .spi_clock_out(pv[6]), .spi_data_out(pv[7]),
    .spi_clock_in(), .spi_data_in(), .i2c_clock_oe(pv[8]), .i2c_data_oe(pv[9]),
    .i2c_clock_in(), .i2c_data_in(), .usart_en(pv[10]), .usart_sync(pv[11]),
    .usart_transmit(pv[12]), .usart_sync_data_out(pv[13]), .usart_receive_in(rx),
    .usart_sync_clock_in(), .ext_digital_clock_in(xclk));
  pcgpio_pads u_pads (.*);
  // Held until pready is sampled high; the idle edge after keeps psel from toggling twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Only the watchdog ends a wait that never sees pready
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'h0, a, 32'h0);
    chk("prdata", e, rd[7:0]);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    results();
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    chk("pin_oe", 8'h00, pin_oe);
    rchk(12'h008, 8'hff);
    rchk(12'h004, 8'h00);
    rchk(12'h014, 8'h01);
    $display("reset test end");
    apb(1'h1, 12'h000, 32'ha5);
    rchk(12'h004, 8'ha5);
    apb(1'h1, 12'h008, 32'hcf);
    ext <= 8'h3c;
    repeat (6) @(posedge pclk);
    chk("pin_oe", 8'h30, pin_oe);
    chk("pin_out", 8'h20, pin_out & pin_oe);
    rchk(12'h008, 8'hcf);
    rchk(12'h000, 8'h2c);
    rchk(12'h018, 8'h00);
    chk("pslverr", 8'h01, {7'h0, er});
    $display("port test end");
    apb(1'h1, 12'h004, 32'h0);
    apb(1'h1, 12'h008, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      pv <= tv[i];
      repeat (3) @(posedge pclk);
      chk("pin_out", te[i], pin_out);
    end
    pv <= 16'h0003;
    apb(1'h1, 12'h00c, 32'hff);
    rchk(12'h00c, 8'he1);
    repeat (2) @(posedge pclk);
    chk("pin_oe", 8'hfb, pin_oe);
    apb(1'h1, 12'h00c, 32'h0);
    apb(1'h1, 12'h014, 32'h5);
    pv <= 16'h0007;
    repeat (3) @(posedge pclk);
    chk("pin_oe", 8'hfb, pin_oe);
    pv <= 16'h8100;
    repeat (3) @(posedge pclk);
    chk("pin_oe", 8'hef, pin_oe);
    $display("override test end");
    apb(1'h1, 12'h008, 32'hff);
    apb(1'h1, 12'h014, 32'h1);
    pv <= 16'h0401;
    ext <= 8'h05;
    repeat (8) @(posedge pclk);
    chk("capture", 8'h01, {7'h0, cap1});
    chk("receive", 8'h00, {7'h0, rx});
    chk("ext_clock", 8'h01, {7'h0, xclk});
    apb(1'h1, 12'h014, 32'h3);
    repeat (3) @(posedge pclk);
    chk("ext_clock", 8'h00, {7'h0, xclk});
    $display("input test end");
    results();
  end
endmodule // pcgpio_port_bench
`default_nettype wire
